// File: logic/kwdt_regs.svh
/*
 * Register map, reset values, keys and timing counts of the keyed watchdog.
 * Assumes byte-wide registers on a plain address/strobe port.
 */
`ifndef KWDT_REGS_SVH
`define KWDT_REGS_SVH

// Register addresses
`define KWDT_ADDR_CTRL 8'h00
`define KWDT_ADDR_FLAGS 8'h01
`define KWDT_ADDR_PINCFG 8'h02
`define KWDT_ADDR_STAT 8'h03
`define KWDT_ADDR_IRQ_STAT 8'h04
`define KWDT_ADDR_IRQ_MASK 8'h05

// Reset values and the pin-select code
`define KWDT_CTRL_RST 8'h52
`define KWDT_PINCFG_RST 8'h55
`define KWDT_PINCFG_PIN 8'haa

// Enable keys in control bits 7..3
`define KWDT_KEY_OFF 5'h15
`define KWDT_KEY_ON 5'h0a

// Field positions
`define KWDT_FLAG_KEY 0
`define KWDT_IRQ_TO 0
`define KWDT_IRQ_KEY 1

// Soft reset delay, in slow ticks
`define KWDT_SOFT_DELAY 8'h10

// Timeout lengths in slow ticks per select code
`define KWDT_DIV_0 19'h00100
`define KWDT_DIV_1 19'h00400
`define KWDT_DIV_2 19'h01000
`define KWDT_DIV_3 19'h04000
`define KWDT_DIV_4 19'h08000
`define KWDT_DIV_5 19'h10000
`define KWDT_DIV_6 19'h20000
`define KWDT_DIV_7 19'h40000

`endif

// File: logic/kwdt_pkg.sv
/*
 * Types shared by the keyed watchdog modules.
 * Assumes kwdt_regs.svh carries all numeric constants.
 */
package kwdt_pkg;

    // Register port request, all fields from the bus master
    typedef struct packed {
        logic wr;        // Write strobe
        logic rd;        // Read strobe
        logic [7:0] addr; // Register address
        logic [7:0] wdata; // Write data
    } kwdt_bus_req_t;

    // Core events, same clock domain
    typedef struct packed {
        logic clear_instr; // Clear watchdog instruction, one cycle
        logic halt_instr;  // Halt instruction, one cycle
        logic sleep;       // Level, high in sleep or idle
    } kwdt_core_t;

    // Main sequencer modes
    typedef enum logic {
        KWDT_RUN,
        KWDT_KEY_DELAY
    } kwdt_mode_t;

endpackage : kwdt_pkg

// File: logic/kwdt_sync.sv
/*
 * Three-stage synchroniser with agreement filter for the watchdog pins.
 * Assumes the inputs are asynchronous to clk_sys.
 */
`timescale 1ns/100ps
module kwdt_sync (
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Async reset, low
    input wire logic [2:0] pins_async, // Raw pins
    output logic [2:0] pins_stable // Filtered levels
);
    import kwdt_pkg::*;

    // All state of the synchroniser
    typedef struct packed {
        logic [2:0] s1; // First stage, read only by s2
        logic [2:0] s2; // Second stage
        logic [2:0] s3; // Third stage
        logic [2:0] out; // Accepted level
    } kwdt_sync_state_t;

    kwdt_sync_state_t st_q;
    kwdt_sync_state_t st_d;

    // Next state; a change counts once stages two and three agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = pins_async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < 3; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    // Pins rest high after reset so the reset pin reads idle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign pins_stable = st_q.out;

endmodule : kwdt_sync

// File: logic/kwdt_tick.sv
/*
 * Slow tick source select and rising-edge detector.
 * Assumes both oscillator levels are already synchronised.
 */
`timescale 1ns/100ps
module kwdt_tick (
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Async reset, low
    input wire logic subclock_source_select, // 1 selects crystal
    input wire logic internal_low_oscillator, // Synced oscillator level
    input wire logic external_low_crystal, // Synced crystal level
    output logic tick // One-cycle pulse per slow period
);
    import kwdt_pkg::*;

    // All state of the tick detector
    typedef struct packed {
        logic prev; // Last selected level
        logic tick; // Registered pulse
    } kwdt_tick_state_t;

    kwdt_tick_state_t st_q;
    kwdt_tick_state_t st_d;
    logic sel_level; // Chosen source

    // Pick the source and flag its rising edge
    always_comb begin
        sel_level = subclock_source_select ? external_low_crystal : internal_low_oscillator; // R1
        st_d.prev = sel_level;
        st_d.tick = sel_level & ~st_q.prev;
    end

    // A source switch can yield one extra or one lost tick; harmless for a watchdog
    // Last level starts high like the synced pins, so no false tick after reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{prev: 1'b1, tick: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule : kwdt_tick

// File: logic/kwdt_top.sv
/*
 * Keyed watchdog timer: control and flag registers, timeout counter,
 * key check with delayed reset, interrupt status and mask.
 * Assumes a core that drives the instruction strobes and the sleep level
 * on clk_sys, and a reset controller that acts on the reset pulses.
 */
// Added by the designer: the strobed register port and the address map.
//
// Operation
// R1: Counter runs on selected slow tick clock.
// R2: Select code picks 2^8 up to 2^18.
// R3: Key 10101 disables, 01010 enables watchdog.
// R4: Other key: delayed reset, sets fault flag.
// R5: Key resets to 01010, watchdog starts enabled.
// R6: Control resets to 0x52, fully read/write.
// R7: Fault flag hardware-set, software writes zero.
// R8: Overflow when awake: device reset, timeout flag.
// R9: Overflow asleep: timeout flag, PC/SP reset.
// R10: Bad key, clear, halt, reset pin clear.
// R11: Software clears only via clear instruction.
// R12: Software clears before timeout elapses.
// R13: Flag register upper bits read zero.
// R14: Halt clears counter, runs only if enabled.
// R15: Slow clock kept on while enabled.
// R16: Free counter overflows at selected power.
// R17: Soft delay counted in slow ticks.
`include "kwdt_regs.svh"
`timescale 1ns/100ps
module kwdt_top (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic arst_n, // Async reset, low
    input kwdt_pkg::kwdt_bus_req_t bus_req, // Register port request
    output logic [7:0] rd_data_q, // Read data, cycle after read
    input kwdt_pkg::kwdt_core_t core_in, // Core instruction events
    input wire logic subclock_source_select, // 1 selects crystal
    input wire logic internal_low_oscillator, // Internal slow oscillator pin
    input wire logic external_low_crystal, // External crystal pin
    input wire logic external_reset_pin_n, // Reset pin, low active
    output logic device_reset_q, // Full device reset pulse
    output logic pcsp_reset_q, // PC and stack pointer reset pulse
    output logic irq_q, // Level interrupt
    output logic slow_clock_keep_on_q // Keep slow oscillator on
);
    import kwdt_pkg::*;

    // All state of the watchdog
    typedef struct packed {
        kwdt_mode_t mode; // Sequencer mode
        logic [7:0] ctrl; // Watchdog control register
        logic [7:0] pincfg; // Reset pin configuration register
        logic key_fault; // Key fault flag
        logic to_flag; // Timeout status flag
        logic [17:0] cnt; // Timeout counter
        logic [7:0] delay; // Soft reset delay counter
        logic [1:0] irq_stat; // Sticky interrupt status
        logic [1:0] irq_mask; // Interrupt mask
        logic [7:0] rd_data; // Read data
        logic dev_rst; // Device reset pulse
        logic pcsp_rst; // PC/SP reset pulse
        logic irq; // Interrupt level
        logic keep_on; // Slow clock request
    } kwdt_top_state_t;

    kwdt_top_state_t st_q; // Registered state
    kwdt_top_state_t st_d; // Next state

    logic [2:0] pins_stable; // Filtered pins
    logic tick; // Slow tick pulse
    logic [4:0] key; // Current enable key
    logic enabled; // Key says enabled
    logic key_valid; // Next key is one of the two
    logic [18:0] limit; // Timeout length in ticks
    logic overflow; // Counter reached its limit
    logic pin_clear; // Reset pin asserted and selected
    logic cnt_clear; // Clear instruction, halt or reset pin clear

    // Timeout length per select code
    function automatic logic [18:0] kwdt_limit(input logic [2:0] sel);
        logic [18:0] r;
        r = `KWDT_DIV_0;
        case (sel)
            3'h0: r = `KWDT_DIV_0;
            3'h1: r = `KWDT_DIV_1;
            3'h2: r = `KWDT_DIV_2;
            3'h3: r = `KWDT_DIV_3;
            3'h4: r = `KWDT_DIV_4;
            3'h5: r = `KWDT_DIV_5;
            3'h6: r = `KWDT_DIV_6;
            default: r = `KWDT_DIV_7;
        endcase
        return r;
    endfunction : kwdt_limit

    // Pins come in through four flops each: three stages plus the filtered output
    kwdt_sync u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pins_async({external_reset_pin_n, external_low_crystal, internal_low_oscillator}),
        .pins_stable(pins_stable)
    );

    // Slow tick from the selected oscillator
    kwdt_tick u_tick (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .subclock_source_select(subclock_source_select),
        .internal_low_oscillator(pins_stable[0]),
        .external_low_crystal(pins_stable[1]),
        .tick(tick)
    );

    // Decoded terms of the current state
    always_comb begin
        key = st_q.ctrl[7:3];
        enabled = (key == `KWDT_KEY_ON); // R3
        limit = kwdt_limit(st_q.ctrl[2:0]); // R2
        overflow = tick && enabled && (st_q.mode == KWDT_RUN) && ({1'b0, st_q.cnt} == (limit - 19'h00001)); // R16
        pin_clear = (st_q.pincfg == `KWDT_PINCFG_PIN) && !pins_stable[2]; // R10
        cnt_clear = core_in.clear_instr || core_in.halt_instr || pin_clear; // R10 R11 R14
    end

    // Next state: bus clears first, hardware sets after so sets win
    always_comb begin
        key_valid = 1'b1;
        st_d = st_q;
        st_d.dev_rst = 1'b0;
        st_d.pcsp_rst = 1'b0;
        st_d.rd_data = 8'h00;

        // Register reads; data stands one cycle only
        if (bus_req.rd) begin
            if (bus_req.addr == `KWDT_ADDR_CTRL) begin
                st_d.rd_data = st_q.ctrl; // R6
            end else if (bus_req.addr == `KWDT_ADDR_FLAGS) begin
                st_d.rd_data = {7'h00, st_q.key_fault}; // R13
            end else if (bus_req.addr == `KWDT_ADDR_PINCFG) begin
                st_d.rd_data = st_q.pincfg;
            end else if (bus_req.addr == `KWDT_ADDR_STAT) begin
                st_d.rd_data = {5'h00, st_q.mode == KWDT_KEY_DELAY, enabled, st_q.to_flag};
            end else if (bus_req.addr == `KWDT_ADDR_IRQ_STAT) begin
                st_d.rd_data = {6'h00, st_q.irq_stat};
                st_d.irq_stat = 2'h0; // Read clears, later sets still win
            end else if (bus_req.addr == `KWDT_ADDR_IRQ_MASK) begin
                st_d.rd_data = {6'h00, st_q.irq_mask};
            end else begin
                st_d.rd_data = 8'h00; // Unmapped reads zero
            end
        end

        // Register writes
        if (bus_req.wr) begin
            if (bus_req.addr == `KWDT_ADDR_CTRL) begin
                st_d.ctrl = bus_req.wdata; // R6
            end else if (bus_req.addr == `KWDT_ADDR_FLAGS) begin
                // Writing one leaves the flag alone
                if (!bus_req.wdata[`KWDT_FLAG_KEY]) begin
                    st_d.key_fault = 1'b0; // R7
                end
            end else if (bus_req.addr == `KWDT_ADDR_PINCFG) begin
                st_d.pincfg = bus_req.wdata;
            end else if (bus_req.addr == `KWDT_ADDR_IRQ_MASK) begin
                st_d.irq_mask = bus_req.wdata[1:0];
            end
        end

        // Clear instruction and halt drop the timeout flag
        if (core_in.clear_instr || core_in.halt_instr) begin
            st_d.to_flag = 1'b0;
        end

        case (st_q.mode)
            KWDT_RUN: begin
                // Counter steps only while enabled; disabled it changes only when a clear source zeroes it
                if (cnt_clear) begin
                    st_d.cnt = 18'h00000; // R10 R14
                end else if (overflow) begin
                    st_d.cnt = 18'h00000; // R16
                end else if (tick && enabled) begin
                    st_d.cnt = st_q.cnt + 18'h00001; // R1
                end

                if (overflow) begin
                    st_d.to_flag = 1'b1; // R8 R9
                    st_d.irq_stat[`KWDT_IRQ_TO] = 1'b1;
                    if (core_in.sleep) begin
                        // Warm reset keeps the registers as they are
                        st_d.pcsp_rst = 1'b1; // R9
                    end else begin
                        st_d.dev_rst = 1'b1; // R8
                        st_d.ctrl = `KWDT_CTRL_RST;
                        st_d.pincfg = `KWDT_PINCFG_RST;
                    end
                end

                // Any key other than the two arms the delayed reset,
                // whether from a write or from a corrupted register
                key_valid = (st_d.ctrl[7:3] == `KWDT_KEY_ON) || (st_d.ctrl[7:3] == `KWDT_KEY_OFF);
                if (!key_valid) begin
                    st_d.mode = KWDT_KEY_DELAY; // R4
                    st_d.delay = `KWDT_SOFT_DELAY; // R17
                    st_d.cnt = 18'h00000; // R10
                end
            end
            KWDT_KEY_DELAY: begin
                // Once armed the reset goes ahead even if the key is fixed,
                // since the register was already seen corrupted
                st_d.cnt = 18'h00000;
                if (tick) begin
                    if (st_q.delay == 8'h00) begin
                        st_d.mode = KWDT_RUN;
                        st_d.dev_rst = 1'b1; // R4
                        st_d.key_fault = 1'b1; // R7
                        st_d.irq_stat[`KWDT_IRQ_KEY] = 1'b1;
                        st_d.ctrl = `KWDT_CTRL_RST; // R5
                        st_d.pincfg = `KWDT_PINCFG_RST;
                    end else begin
                        st_d.delay = st_q.delay - 8'h01; // R17
                    end
                end
            end
            default: begin
                st_d.mode = KWDT_RUN;
            end
        endcase

        // Outputs that follow the next state
        st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
        st_d.keep_on = (st_d.ctrl[7:3] == `KWDT_KEY_ON); // R15
    end

    // Register all state; control starts enabled with select code 2, a 2^12 tick timeout
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q.mode <= KWDT_RUN;
            st_q.ctrl <= `KWDT_CTRL_RST; // R5 R6
            st_q.pincfg <= `KWDT_PINCFG_RST;
            st_q.key_fault <= 1'b0;
            st_q.to_flag <= 1'b0;
            st_q.cnt <= 18'h00000;
            st_q.delay <= 8'h00;
            st_q.irq_stat <= 2'h0;
            st_q.irq_mask <= 2'h0;
            st_q.rd_data <= 8'h00;
            st_q.dev_rst <= 1'b0;
            st_q.pcsp_rst <= 1'b0;
            st_q.irq <= 1'b0;
            st_q.keep_on <= 1'b1; // R15
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign rd_data_q = st_q.rd_data;
    assign device_reset_q = st_q.dev_rst;
    assign pcsp_reset_q = st_q.pcsp_rst;
    assign irq_q = st_q.irq;
    assign slow_clock_keep_on_q = st_q.keep_on;

endmodule : kwdt_top

// File: verification/kwdt_monitor.sv
/*
 * Assertion monitor for the keyed watchdog top.
 * Assumes it is bound to kwdt_top and sees only its ports.
 */
`include "kwdt_regs.svh"
`timescale 1ns/100ps
module kwdt_monitor (
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Async reset, low
    input kwdt_pkg::kwdt_bus_req_t bus_req, // Register request
    input wire logic [7:0] rd_data_q, // Read data
    input kwdt_pkg::kwdt_core_t core_in, // Core events
    input wire logic device_reset_q, // Full reset pulse
    input wire logic pcsp_reset_q, // Warm reset pulse
    input wire logic irq_q, // Interrupt level
    input wire logic slow_clock_keep_on_q // Slow clock request
);
    import kwdt_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Register hit decodes
    wire logic wr_ctrl = bus_req.wr && bus_req.addr == `KWDT_ADDR_CTRL;
    wire logic wr_mask = bus_req.wr && bus_req.addr == `KWDT_ADDR_IRQ_MASK;
    // Read steps
    sequence s_rd_ctrl;
        bus_req.rd && bus_req.addr == `KWDT_ADDR_CTRL;
    endsequence
    sequence s_rd_flags;
        bus_req.rd && bus_req.addr == `KWDT_ADDR_FLAGS;
    endsequence
    sequence s_rd_irq;
        bus_req.rd && bus_req.addr == `KWDT_ADDR_IRQ_STAT;
    endsequence
    a_rd_idle: assert property (!bus_req.rd |=> rd_data_q == 8'h00)
        else $error("read data not idle");
    a_ctrl_back: assert property (wr_ctrl ##2 s_rd_ctrl |=>
        rd_data_q == $past(bus_req.wdata, 3) || $past(device_reset_q) || $past(device_reset_q, 2))
        else $error("control readback");
    a_flags_upper: assert property (s_rd_flags |=> rd_data_q[7:1] == 7'h00)
        else $error("flag upper bits set");
    // Only one kind of reset at a time, each one cycle
    a_reset_kinds: assert property (!(device_reset_q && pcsp_reset_q))
        else $error("both resets at once");
    a_dev_pulse: assert property (device_reset_q |=> !device_reset_q)
        else $error("device reset too long");
    a_warm_sleep: assert property (pcsp_reset_q |-> $past(core_in.sleep) && !$past(pcsp_reset_q))
        else $error("warm reset while awake");
    // Key writes steer the slow clock request
    a_key_on: assert property (wr_ctrl && bus_req.wdata[7:3] == `KWDT_KEY_ON |->
        ##[1:2] slow_clock_keep_on_q) else $error("slow clock not kept on");
    a_key_off: assert property (wr_ctrl && bus_req.wdata[7:3] == `KWDT_KEY_OFF |->
        ##[1:2] (!slow_clock_keep_on_q || device_reset_q)) else $error("slow clock kept on");
    // Interrupt follows status events and reads
    a_irq_clear: assert property (s_rd_irq |=> !irq_q || device_reset_q || pcsp_reset_q)
        else $error("interrupt not cleared by read");
    a_irq_cause: assert property ($rose(irq_q) |-> device_reset_q || pcsp_reset_q
        || $past(wr_mask) || $past(wr_mask, 2)) else $error("interrupt without cause");
endmodule : kwdt_monitor

// File: verification/kwdt_testbench.sv
/*
 * Self-checking bench for the keyed watchdog top: registers, timeouts,
 * clear sources, sleep and bad-key scenarios against a small model.
 * Assumes the design files and kwdt_monitor.sv are compiled first.
 */
`include "kwdt_regs.svh"
`timescale 1ns/100ps
module testbench;
    import kwdt_pkg::*;
    logic clk_sys; // System clock
    logic arst_n; // Async reset, low
    kwdt_bus_req_t bus_req; // Register requests
    kwdt_core_t core_in; // Core events
    logic [7:0] rd_data_q; // Read data
    logic src_sel; // 1 runs the crystal
    logic pin_n; // Reset pin level
    logic [3:0] ph_q; // Slow wave phase, period 16 cycles
    logic dev_rst; // Full reset pulse
    logic pcsp_rst; // Warm reset pulse
    logic irq; // Interrupt
    logic keep_on; // Slow clock request
    int n_errors = 0; // Mismatches
    int cmp_count = 0; // Comparisons
    int n_rise = 0; // Slow rises since last sync
    int seed = 13032; // Xorshift state
    int sel; // Chosen timeout code
    int key; // Chosen bad key

    // Unselected slow source is held still, so a wrong mux shows
    kwdt_top u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .rd_data_q(rd_data_q),
        .core_in(core_in), .subclock_source_select(src_sel),
        .internal_low_oscillator(ph_q[3] & ~src_sel), .external_low_crystal(ph_q[3] & src_sel),
        .external_reset_pin_n(pin_n), .device_reset_q(dev_rst), .pcsp_reset_q(pcsp_rst),
        .irq_q(irq), .slow_clock_keep_on_q(keep_on)
    );

    // System clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Slow wave and its rise counter
    always @(posedge clk_sys) begin
        ph_q <= ph_q + 4'h1;
        if (ph_q == 4'h7) n_rise <= n_rise + 1;
    end

    // Timeout model: ticks per select code
    function automatic int ovf_ticks(input int s);
        int pw[8] = '{8, 10, 12, 14, 15, 16, 17, 18};
        return 1 << pw[s];
    endfunction : ovf_ticks

    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic check(input bit ok, input string what);
        cmp_count++;
        if (!ok) begin
            n_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    // Bus cycles; each waits an edge first so strobes never double up
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        // Data stands from this edge to the next; look once it has settled
        #1;
        check(rd_data_q === e, "read data");
    endtask : rd

    // Late in the high half of the slow wave, away from tick edges
    task automatic sync_low();
        do @(posedge clk_sys); while (ph_q != 4'he);
        n_rise = 0;
    endtask : sync_low

    task automatic wait_pulse(input int n, input logic warm);
        for (int k = 0; k < n * 16 + 100 && !(dev_rst || pcsp_rst); k++) @(posedge clk_sys);
        check(n_rise == n, "slow ticks before reset");
        check(pcsp_rst === warm && dev_rst === !warm, "reset kind");
    endtask : wait_pulse

    // Clear by instruction, halt or pin, then run to overflow
    task automatic run_ovf(input int how, input int n, input logic warm);
        sync_low();
        if (how == 0) core_in.clear_instr <= 1'b1;
        else if (how == 1) core_in.halt_instr <= 1'b1;
        else pin_n <= 1'b0;
        @(posedge clk_sys);
        core_in.clear_instr <= 1'b0;
        core_in.halt_instr <= 1'b0;
        repeat (4) @(posedge clk_sys);
        pin_n <= 1'b1;
        wait_pulse(n, warm);
    endtask : run_ovf

    task automatic end_of_test();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // Hang guard, sized well above the longest run
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        bus_req = '0;
        core_in = '0;
        src_sel = 1'b0;
        pin_n = 1'b1;
        ph_q = 4'h0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(`KWDT_ADDR_CTRL, `KWDT_CTRL_RST);
        rd(`KWDT_ADDR_FLAGS, 8'h00);
        rd(8'h07, 8'h00);
        check(keep_on === 1'b1, "enabled after reset");
        $display("test reset done");
        // Disabled: halt clears, then counter stays stopped
        wr(`KWDT_ADDR_CTRL, {`KWDT_KEY_OFF, 3'b000});
        rd(`KWDT_ADDR_CTRL, {`KWDT_KEY_OFF, 3'b000});
        check(keep_on === 1'b0, "slow clock released");
        core_in.halt_instr <= 1'b1;
        @(posedge clk_sys);
        core_in.halt_instr <= 1'b0;
        for (int k = 0; k < 300 * 16; k++) begin
            @(posedge clk_sys);
            check(dev_rst === 1'b0 && pcsp_rst === 1'b0, "reset while disabled");
        end
        $display("test disabled done");
        // Each clear source, random timeout code, both slow sources
        wr(`KWDT_ADDR_IRQ_MASK, 8'h01);
        for (int how = 0; how < 3; how++) begin
            sel = xs() & 1;
            src_sel <= how[0];
            wr(`KWDT_ADDR_PINCFG, `KWDT_PINCFG_PIN);
            wr(`KWDT_ADDR_CTRL, {`KWDT_KEY_ON, sel[2:0]});
            run_ovf(how, ovf_ticks(sel), 1'b0);
            check(irq === 1'b1, "timeout interrupt");
            rd(`KWDT_ADDR_CTRL, `KWDT_CTRL_RST);
            rd(`KWDT_ADDR_IRQ_STAT, 8'h01);
            check(irq === 1'b0, "interrupt kept after read");
        end
        $display("test overflow done");
        // Asleep: warm reset only, interrupt masked
        wr(`KWDT_ADDR_IRQ_MASK, 8'h00);
        wr(`KWDT_ADDR_CTRL, {`KWDT_KEY_ON, 3'b000});
        core_in.sleep <= 1'b1;
        run_ovf(0, ovf_ticks(0), 1'b1);
        check(irq === 1'b0, "masked interrupt raised");
        rd(`KWDT_ADDR_STAT, 8'h03);
        rd(`KWDT_ADDR_CTRL, {`KWDT_KEY_ON, 3'b000});
        rd(`KWDT_ADDR_IRQ_STAT, 8'h01);
        core_in.sleep <= 1'b0;
        $display("test sleep done");
        // Bad key: delayed reset and sticky fault flag
        do key = xs() & 31; while (key == `KWDT_KEY_ON || key == `KWDT_KEY_OFF);
        wr(`KWDT_ADDR_IRQ_MASK, 8'h02);
        sync_low();
        wr(`KWDT_ADDR_CTRL, {key[4:0], 3'b000});
        wait_pulse(`KWDT_SOFT_DELAY + 1, 1'b0);
        check(irq === 1'b1, "key fault interrupt");
        rd(`KWDT_ADDR_FLAGS, 8'h01);
        wr(`KWDT_ADDR_FLAGS, 8'hff);
        rd(`KWDT_ADDR_FLAGS, 8'h01);
        wr(`KWDT_ADDR_FLAGS, 8'h00);
        rd(`KWDT_ADDR_FLAGS, 8'h00);
        rd(`KWDT_ADDR_IRQ_STAT, 8'h02);
        rd(`KWDT_ADDR_CTRL, `KWDT_CTRL_RST);
        $display("test key fault done");
        end_of_test();
    end
endmodule : testbench

bind kwdt_top kwdt_monitor u_mon (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .rd_data_q(rd_data_q),
    .core_in(core_in), .device_reset_q(device_reset_q), .pcsp_reset_q(pcsp_reset_q),
    .irq_q(irq_q), .slow_clock_keep_on_q(slow_clock_keep_on_q)
);
